// *** sbsr_ctrl_model.sv ***
// serial-poll controller model facing the service-request block
`timescale 1ns/1ps
`default_nettype none
module sbsr_ctrl_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // poll request from the bench, slow gives a late answer
  input  wire logic       poll_req,
  input  wire logic       slow,
  // device side
  input  wire logic [7:0] poll_byte,
  output logic            serial_poll_read,
  // result of the last poll
  output logic [7:0]      poll_val,
  output logic            poll_done,
  output logic            ready_seen
);
  logic [2:0] cnt_q;

  // poll enable, talk address, take the byte, untalk; the byte is the only status path
  always @(posedge clk) begin
    if (rst) begin
      cnt_q            <= 3'h0;
      poll_val         <= 8'h00;
      ready_seen       <= 1'b0;
      serial_poll_read <= 1'b0;
      poll_done        <= 1'b0;
    end else begin
      // one assignment per edge, so the strobe never glitches
      serial_poll_read <= (cnt_q == 3'h1);
      poll_done        <= (cnt_q == 3'h1);
      if (cnt_q == 3'h0) begin
        if (poll_req) cnt_q <= slow ? 3'h5 : 3'h1;
      end else if (cnt_q == 3'h1) begin
        poll_val   <= poll_byte;
        // a setting change counts as processed only once ready is seen here
        ready_seen <= poll_byte[4];
        cnt_q      <= 3'h0;
      end else begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule // sbsr_ctrl_model
`default_nettype wire

// *** sbsr_pkg.sv ***
// package: status byte layout, reset values, command codes and fault queue sizing for the service-request block
package sbsr_pkg;
  // ****************************************************************
  // status byte field positions
  // ****************************************************************
  localparam int unsigned SB_SWEEP_DONE = 0;
  localparam int unsigned SB_HW_FAULT   = 1;
  localparam int unsigned SB_EXEC_FAULT = 2;
  localparam int unsigned SB_LOCAL      = 3;
  localparam int unsigned SB_READY      = 4;
  localparam int unsigned SB_SUM_ERR    = 5;
  localparam int unsigned SB_REQUEST    = 6;
  localparam int unsigned SB_PARAM_CHG  = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // bits that a status clear leaves alone (local/remote, ready)
  localparam logic [7:0] CLEAR_KEEP   = 8'h18;
  // bits that take part in the mask compare (all but the request bit)
  localparam logic [7:0] REQ_SOURCES  = 8'hbf;

  // ****************************************************************
  // decoded instrument commands, one-hot pulses on the cmd port
  // ****************************************************************
  localparam int unsigned CMD_W            = 8;
  localparam int unsigned CMD_CLEAR_STATUS = 0;
  localparam int unsigned CMD_PRESET       = 1;
  localparam int unsigned CMD_READ_HW      = 2;
  localparam int unsigned CMD_READ_EXEC    = 3;
  localparam int unsigned CMD_READ_PARAM   = 4;
  localparam int unsigned CMD_WRITE_MASK   = 5;
  localparam int unsigned CMD_SHOW_LAST    = 6;
  localparam int unsigned CMD_SWEEP_SEL    = 7;

  // ****************************************************************
  // fault queue
  // ****************************************************************
  localparam int unsigned FAULT_W     = 8;
  localparam int unsigned FAULT_DEPTH = 4;
  localparam logic [7:0]  FAULT_NONE  = 8'h00;
endpackage : sbsr_pkg

// *** sbsr_status.sv ***
// status byte, service request, addressing state and indicators of the bus interface
`timescale 1ns/1ps
`default_nettype none

// ******************************************************************
// status byte and service request
// ******************************************************************
// Summary of operation
// R1: with request bit clear, a poll returns live status.
// R2: with request bit set, a poll returns snapshot; next poll refreshes it.
// R3: a poll never clears a status bit by itself.
// R4: clear-status, preset, device clear, power-on clear byte if no hardware fault.
// R5: local/remote and ready bits ignore clears and always show live values.
// R6: bit 0 set on single sweep done, cleared on new sweep selection.
// R7: bit 1 set on hardware fault, cleared only by read-hardware-fault.
// R8: queued faults; after read-hardware-fault one code per talk addressing.
// R9: bit 2 set on execution fault, cleared by read-execution-fault, code kept.
// R10: bit 3 set in local mode, clear in remote.
// R11: bit 4 normally set; controller waits for a poll showing it.
// R12: bit 5 is the OR of bits 1 and 2.
// R13: bit 6 set when mask AND status nonzero, excluding bit 6.
// R14: bit 7 set on automatic setting change, cleared by read-parameter-changed.
// R15: interface clear drops talker and listener at once.
// R16: bus trigger message is ignored.
// R17: no parallel poll; no parallel-poll response driven.
// R18: listener held until talk address, interface clear, unlisten or power-on.
// R19: talker held until listen address, clear, other talk, untalk or power-on.
// R20: indicators for remote, listener, talker, and request while asserting SRQ.
// R21: show-last-settings command in remote mode pulses display request.
// R22: bits 0..5 and 7 masked by 8-bit mask; nonzero sets bit 6 and SRQ.
// R23: mask is zero after power-on and preset.
// R24: status byte only leaves by serial poll.
module sbsr_status #(
  parameter int unsigned FAULT_DEPTH = sbsr_pkg::FAULT_DEPTH
) (
  // clock and reset (reset doubles as power-on)
  input  wire logic                         clk,
  input  wire logic                         rst,
  // decoded commands, one-cycle pulses, and their data
  input  wire logic [sbsr_pkg::CMD_W-1:0]   cmd,
  input  wire logic [7:0]                   cmd_data,
  input  wire logic                         device_clear,
  // instrument events, one-cycle pulses with their codes; ready is a level
  input  wire logic                         sweep_done,
  input  wire logic                         hw_fault,
  input  wire logic [sbsr_pkg::FAULT_W-1:0] hw_fault_code,
  input  wire logic                         exec_fault,
  input  wire logic [sbsr_pkg::FAULT_W-1:0] exec_fault_code,
  input  wire logic                         param_changed,
  input  wire logic [sbsr_pkg::FAULT_W-1:0] param_code,
  input  wire logic                         ready,
  // bus interface events, pins pass a 3-stage filter
  input  wire logic                         ifc_pin,
  input  wire logic                         remote_pin,
  input  wire logic                         my_talk_addr,
  input  wire logic                         my_listen_addr,
  input  wire logic                         other_talk_addr,
  input  wire logic                         untalk,
  input  wire logic                         unlisten,
  input  wire logic                         trigger,
  input  wire logic                         serial_poll_read,
  // outputs
  output logic [7:0]                        poll_byte,
  output logic                              srq,
  output logic [sbsr_pkg::FAULT_W-1:0]      talk_data,
  output logic [sbsr_pkg::FAULT_W-1:0]      exec_code,
  output logic [sbsr_pkg::FAULT_W-1:0]      param_code_q_out,
  output logic                              ppoll_resp,
  output logic                              show_last_settings,
  output logic                              remote_indicator,
  output logic                              listener_indicator,
  output logic                              talker_indicator,
  output logic                              request_indicator
);
  import sbsr_pkg::*;

  localparam int unsigned PTR_W = (FAULT_DEPTH > 1) ? $clog2(FAULT_DEPTH) : 1;

  // ****************************************************************
  // pin filters: three stages, change accepted when 2nd and 3rd agree
  // ****************************************************************
  logic [2:0] ifc_sync_q;
  logic [2:0] rem_sync_q;
  logic       ifc_q;
  logic       remote_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ifc_sync_q <= 3'h0;
      rem_sync_q <= 3'h0;
    end else begin
      ifc_sync_q <= {ifc_sync_q[1:0], ifc_pin};
      rem_sync_q <= {rem_sync_q[1:0], remote_pin};
    end
  end

  // filtered levels only follow once two late stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      ifc_q    <= 1'b0;
      remote_q <= 1'b0;
    end else begin
      if (ifc_sync_q[1] == ifc_sync_q[2]) ifc_q <= ifc_sync_q[2];
      if (rem_sync_q[1] == rem_sync_q[2]) remote_q <= rem_sync_q[2];
    end
  end

  // ****************************************************************
  // clears and mask
  // ****************************************************************
  logic       hw_unresolved;
  logic       byte_clear;
  logic [7:0] mask_q;

  // a byte clear is refused while the hardware bit is set or a hardware fault is still queued
  assign byte_clear = (cmd[CMD_CLEAR_STATUS] | cmd[CMD_PRESET] | device_clear)
                      & ~hw_unresolved; // R4

  // mask zero at power-on and preset; preset wins over a same-cycle write
  always_ff @(posedge clk) begin
    if (rst || cmd[CMD_PRESET]) begin
      mask_q <= MASK_RESET; // R23
    end else if (cmd[CMD_WRITE_MASK]) begin
      mask_q <= cmd_data;
    end
  end

  // ****************************************************************
  // sticky status bits; a set in the clear cycle wins
  // ****************************************************************
  logic sweep_q;
  logic hw_q;
  logic exec_q;
  logic param_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sweep_q <= 1'b0;
    end else if (sweep_done) begin
      sweep_q <= 1'b1; // R6
    end else if (cmd[CMD_SWEEP_SEL] || byte_clear) begin
      sweep_q <= 1'b0; // R6
    end
  end

  // hardware bit ignores byte clears; only read-hardware-fault drops it
  always_ff @(posedge clk) begin
    if (rst) begin
      hw_q <= 1'b0;
    end else if (hw_fault) begin
      hw_q <= 1'b1; // R7
    end else if (cmd[CMD_READ_HW]) begin
      hw_q <= 1'b0; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      exec_q <= 1'b0;
    end else if (exec_fault) begin
      exec_q <= 1'b1; // R9
    end else if (cmd[CMD_READ_EXEC] || byte_clear) begin
      exec_q <= 1'b0; // R9
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      param_q <= 1'b0;
    end else if (param_changed) begin
      param_q <= 1'b1; // R14
    end else if (cmd[CMD_READ_PARAM] || byte_clear) begin
      param_q <= 1'b0; // R14
    end
  end

  // fault codes kept for the read commands
  always_ff @(posedge clk) begin
    if (rst) begin
      exec_code        <= FAULT_NONE;
      param_code_q_out <= FAULT_NONE;
    end else begin
      if (exec_fault) exec_code <= exec_fault_code; // R9
      if (param_changed) param_code_q_out <= param_code; // R14
    end
  end

  // ****************************************************************
  // live byte and request
  // ****************************************************************
  logic [7:0] live_byte;
  logic       req_hit;

  always_comb begin
    live_byte                = STATUS_RESET;
    live_byte[SB_SWEEP_DONE] = sweep_q;
    live_byte[SB_HW_FAULT]   = hw_q;
    live_byte[SB_EXEC_FAULT] = exec_q;
    live_byte[SB_LOCAL]      = ~remote_q; // R10 R5
    live_byte[SB_READY]      = ready;     // R11 R5
    live_byte[SB_SUM_ERR]    = hw_q | exec_q; // R12
    live_byte[SB_PARAM_CHG]  = param_q;
    live_byte[SB_REQUEST]    = req_hit;
  end

  // the request bit itself is kept out of the compare
  assign req_hit = |(mask_q & REQ_SOURCES & live_byte); // R13 R22
  assign srq     = req_hit; // R22

  // ****************************************************************
  // poll snapshot: frozen while the request bit is set
  // ****************************************************************
  logic [7:0] snap_q;
  logic       snap_valid_q;

  // snapshot taken when request first sets, refreshed at each poll with it set
  always_ff @(posedge clk) begin
    if (rst) begin
      snap_q       <= STATUS_RESET;
      snap_valid_q <= 1'b0;
    end else if (!req_hit) begin
      snap_valid_q <= 1'b0;
      snap_q       <= live_byte;
    end else if (!snap_valid_q || serial_poll_read) begin
      snap_valid_q <= 1'b1; // R2
      snap_q       <= live_byte; // R2
    end
  end

  // local and ready bits always live, even in a frozen byte
  always_comb begin
    if (snap_valid_q) begin
      poll_byte = (snap_q & ~CLEAR_KEEP) | (live_byte & CLEAR_KEEP); // R2 R5
    end else begin
      poll_byte = live_byte; // R1
    end
  end
  // polling changes no status bit: serial_poll_read only steers the snapshot (R3, R24)

  // ****************************************************************
  // hardware fault queue
  // ****************************************************************
  logic [FAULT_W-1:0] fq_mem [FAULT_DEPTH];
  logic [PTR_W-1:0]   fq_wr_q;
  logic [PTR_W-1:0]   fq_rd_q;
  logic [PTR_W:0]     fq_cnt_q;
  logic               fq_out_q;
  logic               fq_push;
  logic               fq_pop;

  // when full, newest faults are dropped; the bit still records them
  assign fq_push       = hw_fault && (fq_cnt_q != (PTR_W+1)'(FAULT_DEPTH)); // R8
  assign fq_pop        = fq_out_q && my_talk_addr && (fq_cnt_q != '0); // R8
  assign hw_unresolved = hw_q || (fq_cnt_q != '0);

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(FAULT_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk) begin
    if (fq_push) fq_mem[fq_wr_q] <= hw_fault_code;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fq_wr_q  <= '0;
      fq_rd_q  <= '0;
      fq_cnt_q <= '0;
    end else begin
      if (fq_push) fq_wr_q <= ptr_inc(fq_wr_q);
      if (fq_pop) fq_rd_q <= ptr_inc(fq_rd_q);
      fq_cnt_q <= fq_cnt_q + (PTR_W+1)'(fq_push) - (PTR_W+1)'(fq_pop);
    end
  end

  // output mode armed by read-hardware-fault, one code per talk address
  always_ff @(posedge clk) begin
    if (rst) begin
      fq_out_q  <= 1'b0;
      talk_data <= FAULT_NONE;
    end else begin
      if (cmd[CMD_READ_HW]) fq_out_q <= 1'b1;
      else if (fq_out_q && my_talk_addr && fq_cnt_q == '0) fq_out_q <= 1'b0;
      if (my_talk_addr) begin
        talk_data <= (fq_out_q && fq_cnt_q != '0) ? fq_mem[fq_rd_q] : FAULT_NONE; // R8
      end
    end
  end

  // ****************************************************************
  // talker and listener state
  // ****************************************************************
  logic talk_q;
  logic listen_q;

  // interface clear beats any address in the same cycle
  always_ff @(posedge clk) begin
    if (rst || ifc_q) begin
      listen_q <= 1'b0; // R15 R18
    end else if (my_talk_addr || unlisten) begin
      listen_q <= 1'b0; // R18
    end else if (my_listen_addr) begin
      listen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ifc_q) begin
      talk_q <= 1'b0; // R15 R19
    end else if (my_listen_addr || other_talk_addr || untalk) begin
      talk_q <= 1'b0; // R19
    end else if (my_talk_addr) begin
      talk_q <= 1'b1;
    end
  end

  // ****************************************************************
  // indicators, display request, unused messages
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      show_last_settings <= 1'b0;
    end else begin
      show_last_settings <= cmd[CMD_SHOW_LAST] & remote_q; // R21
    end
  end

  assign remote_indicator   = remote_q; // R20
  assign listener_indicator = listen_q; // R20
  assign talker_indicator   = talk_q;   // R20
  assign request_indicator  = srq & poll_byte[SB_REQUEST]; // R20
  // trigger has no path into any state
  assign ppoll_resp = 1'b0 & trigger; // R16 R17

  // ****************************************************************
  // checks
  // ****************************************************************
  // summary bit checked on the byte the controller sees, frozen or live
  a_sum_error: assert property (@(posedge clk) disable iff (rst) // R12
    poll_byte[SB_SUM_ERR] == (poll_byte[SB_HW_FAULT] | poll_byte[SB_EXEC_FAULT]))
    else $error("summary bit differs from fault bits");
  a_req_mask: assert property (@(posedge clk) disable iff (rst) // R13 R22
    srq == |(mask_q & {param_q, 1'b0, hw_q | exec_q, ready, ~remote_q, exec_q, hw_q, sweep_q}))
    else $error("srq does not follow masked status");
  a_mask_preset: assert property (@(posedge clk) disable iff (rst) // R23
    cmd[CMD_PRESET] |=> (mask_q == 8'h00) && !srq)
    else $error("mask not zero after preset");
  a_hw_sticky: assert property (@(posedge clk) disable iff (rst) // R7
    hw_q && !cmd[CMD_READ_HW] |=> hw_q)
    else $error("hardware bit dropped without read command");
  a_live_unreq: assert property (@(posedge clk) disable iff (rst) // R1
    !snap_valid_q |-> poll_byte == live_byte)
    else $error("poll byte not live without request");
  a_snap_hold: assert property (@(posedge clk) disable iff (rst) // R2
    snap_valid_q && req_hit && !serial_poll_read |=> $stable(snap_q))
    else $error("snapshot moved without a poll");
  a_ifc_drop: assert property (@(posedge clk) disable iff (rst) // R15
    ifc_q |=> !talk_q && !listen_q)
    else $error("addressed state survived interface clear");
  a_talk_hold: assert property (@(posedge clk) disable iff (rst) // R19
    talk_q && !ifc_q && !my_listen_addr && !other_talk_addr && !untalk |=> talk_q)
    else $error("talker dropped without cause");
  a_exec_sticky: assert property (@(posedge clk) disable iff (rst) // R9
    exec_fault |=> exec_q && (poll_byte[SB_SUM_ERR] || snap_valid_q))
    else $error("execution bit not set by fault");
endmodule : sbsr_status

`default_nettype wire

// *** status_byte_service_request_test.sv ***
// self-checking bench for the status byte and service-request block
`timescale 1ns/1ps
`default_nettype none
module status_byte_service_request_test;
  import sbsr_pkg::*;
  logic        clk, rst, ready, ifc_pin, remote_pin, poll_req, slow, poll_done;
  logic        srq, ppoll_resp, show_last_settings, remote_indicator, serial_poll_read;
  logic        listener_indicator, talker_indicator, request_indicator;
  logic        sw, ex, pc, rdy, seen, ready_seen;
  logic [10:0] ev;
  logic [7:0]  cmd, code, poll_byte, poll_val, talk_data, exec_code, param_code_q_out;
  logic [7:0]  m, e;
  int          n_errors, samples_checked;
  int          stp [10] = '{6, 5, 9, 6, 9, 5, 7, 5, 8, 10};
  logic [1:0]  lt [10] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};

  // ****************************************************************
  // design and controller model
  // ****************************************************************
  // one code bus feeds every code input and the mask data
  sbsr_status #(.FAULT_DEPTH(4)) uut (
    .clk, .rst, .cmd, .cmd_data(code), .device_clear(ev[4]),
    .sweep_done(ev[0]), .hw_fault(ev[1]), .hw_fault_code(code), .exec_fault(ev[2]),
    .exec_fault_code(code), .param_changed(ev[3]), .param_code(code), .ready,
    .ifc_pin, .remote_pin, .my_talk_addr(ev[5]), .my_listen_addr(ev[6]),
    .other_talk_addr(ev[7]), .untalk(ev[8]), .unlisten(ev[9]), .trigger(ev[10]),
    .serial_poll_read, .poll_byte, .srq, .talk_data, .exec_code, .param_code_q_out,
    .ppoll_resp, .show_last_settings, .remote_indicator, .listener_indicator,
    .talker_indicator, .request_indicator
  );
  sbsr_ctrl_model ctrl (
    .clk, .rst, .poll_req, .slow, .poll_byte, .serial_poll_read, .poll_val, .poll_done,
    .ready_seen
  );

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // tasks and expectations
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle command and event pulses, then time for the status to settle
  task automatic fire(input logic [7:0] c, input logic [10:0] v, input logic [7:0] d);
    @(posedge clk);
    cmd  <= c;
    ev   <= v;
    code <= d;
    @(posedge clk);
    cmd <= 8'h00;
    ev  <= 11'h0;
    tick(2);
  endtask

  // serial poll through the model, bounded wait for its answer
  task automatic poll(input logic [7:0] exp, input logic s);
    int k;
    @(posedge clk);
    slow     <= s;
    poll_req <= 1'b1;
    @(posedge clk);
    poll_req <= 1'b0;
    // sample off the edge so the model's pulse is settled
    for (k = 0; k < 20 && poll_done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 20) begin
      n_errors++;
      test_done();
    end
    chk(poll_val, exp);
    tick(2);
  endtask

  // status byte in remote mode with no hardware fault
  function automatic logic [7:0] exp_b(input logic sw, ex, pc, rdy, input logic [7:0] m);
    logic [7:0] b;
    b = {pc, 1'b0, ex, rdy, 1'b0, ex, 1'b0, sw};
    b[SB_REQUEST] = |(b & m & REQ_SOURCES);
    return b;
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst, ready} = 2'h3;
    {ifc_pin, remote_pin, poll_req, slow} = 4'h0;
    {cmd, code, ev} = 27'h0;
    n_errors = 0;
    samples_checked = 0;
    void'($urandom(32'hcc09));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(6);
    // power-on state, ready followed live
    chk(poll_byte, 8'h18);
    chk(8'(srq), 8'h00);
    chk(8'(ppoll_resp), 8'h00);
    chk(8'({listener_indicator, talker_indicator}), 8'h00);
    @(posedge clk);
    ready <= 1'b0;
    tick(2);
    poll(8'h08, 1'b0);
    chk(8'(ready_seen), 8'h00);
    @(posedge clk);
    ready <= 1'b1;
    // snapshot held while the request bit is up, refreshed by a poll
    fire(8'h20, 11'h0, 8'h01);
    fire(8'h00, 11'h1, 8'h00);
    chk(8'({srq, request_indicator}), 8'h03);
    fire(8'h00, 11'h4, 8'h5a);
    chk(poll_byte, 8'h59);
    chk(exec_code, 8'h5a);
    poll(8'h59, 1'b1);
    chk(8'(ready_seen), 8'h01);
    chk(poll_byte, 8'h7d);
    fire(8'h80, 11'h0, 8'h00);
    chk(poll_byte, 8'h3c);
    chk(8'(srq), 8'h00);
    fire(8'h08, 11'h0, 8'h00);
    chk(poll_byte, 8'h18);
    // queued hardware faults survive clears, read back one per talk address
    fire(8'h00, 11'h2, 8'h11);
    fire(8'h00, 11'h2, 8'h22);
    chk(poll_byte, 8'h3a);
    fire(8'h01, 11'h0, 8'h00);
    fire(8'h00, 11'h10, 8'h00);
    chk(poll_byte, 8'h3a);
    fire(8'h04, 11'h0, 8'h00);
    chk(poll_byte, 8'h18);
    fire(8'h00, 11'h20, 8'h00);
    chk(talk_data, 8'h11);
    fire(8'h00, 11'h20, 8'h00);
    chk(talk_data, 8'h22);
    fire(8'h00, 11'h20, 8'h00);
    chk(talk_data, 8'h00);
    // parameter change, preset zeroes the mask, device clear and read clear
    fire(8'h20, 11'h0, 8'h80);
    fire(8'h00, 11'h8, 8'h33);
    chk(param_code_q_out, 8'h33);
    chk(8'(srq), 8'h01);
    fire(8'h02, 11'h0, 8'h00);
    chk(poll_byte, 8'h18);
    fire(8'h00, 11'h8, 8'h34);
    chk(poll_byte, 8'h98);
    fire(8'h10, 11'h0, 8'h00);
    chk(poll_byte, 8'h18);
    fire(8'h00, 11'h9, 8'h00);
    fire(8'h00, 11'h10, 8'h00);
    chk(poll_byte, 8'h18);
    // addressing walk; the trigger step must change nothing
    for (int i = 0; i < 10; i++) begin
      fire(8'h00, 11'(1 << stp[i]), 8'h00);
      chk(8'({listener_indicator, talker_indicator}), 8'(lt[i]));
      chk(poll_byte, 8'h18);
    end
    // interface clear drops listener and talker; pin goes through a filter
    for (int j = 0; j < 2; j++) begin
      fire(8'h00, (j == 0) ? 11'h40 : 11'h20, 8'h00);
      chk(8'({listener_indicator, talker_indicator}), (j == 0) ? 8'h02 : 8'h01);
      @(posedge clk);
      ifc_pin <= 1'b1;
      tick(6);
      chk(8'({listener_indicator, talker_indicator}), 8'h00);
      @(posedge clk);
      ifc_pin <= 1'b0;
      // let the filtered clear drop before the next address
      tick(6);
    end
    // remote mode and the show-last-settings pulse
    @(posedge clk);
    remote_pin <= 1'b1;
    tick(6);
    chk(8'(remote_indicator), 8'h01);
    chk(poll_byte, 8'h10);
    @(posedge clk);
    cmd <= 8'h40;
    @(posedge clk);
    cmd <= 8'h00;
    #1 seen = show_last_settings;
    repeat (3) @(posedge clk) #1 seen |= show_last_settings;
    chk(8'(seen), 8'h01);
    // random masks and events; mask written last so the snapshot holds them
    for (int i = 0; i < 24; i++) begin
      m = 8'($urandom);
      {sw, ex, pc, rdy} = 4'($urandom);
      @(posedge clk);
      ready <= rdy;
      fire(8'h00, {7'h0, pc, ex, 1'b0, sw}, 8'($urandom));
      fire(8'h20, 11'h0, m);
      e = exp_b(sw, ex, pc, rdy, m);
      chk(poll_byte, e);
      chk(8'({srq, request_indicator}), {6'h0, e[6], e[6]});
      fire(8'h20, 11'h0, 8'h00);
      fire(8'h01, 11'h0, 8'h00);
    end
    test_done();
  end
endmodule // status_byte_service_request_test
`default_nettype wire
